// ===== rtl/uvs_pkg.sv
// uvs_pkg: register map, field positions, reset values and timing counts
// for the uv sensor operational state control register bank.
// assumes a byte-wide register port already decoded from the serial bus.
package uvs_pkg;
  // register offsets (4 lsbs of the serial address)
  localparam logic [3:0] UVS_ADDR_OSC = 4'h0;
  localparam logic [3:0] UVS_ADDR_TEMP = 4'h1;
  localparam logic [3:0] UVS_ADDR_GEN = 4'h2;
  localparam logic [3:0] UVS_ADDR_RES_LO = 4'h2;
  localparam logic [3:0] UVS_ADDR_RES_HI = 4'h4;
  localparam logic [3:0] UVS_ADDR_CTRL_LO = 4'h6;
  localparam logic [3:0] UVS_ADDR_CTRL_HI = 4'hB;
  // state register field positions
  localparam int UVS_BIT_START = 7;
  localparam int UVS_BIT_PD = 6;
  localparam int UVS_BIT_SRST = 3;
  localparam int UVS_SEL_HI = 2;
  // state select codes
  localparam logic [2:0] UVS_SEL_CONFIG = 3'h2;
  localparam logic [2:0] UVS_SEL_MEAS = 3'h3;
  // reset values
  localparam logic UVS_RST_START = 1'b0;
  localparam logic UVS_RST_PD = 1'b1;
  localparam logic [7:0] UVS_RST_CTRL = 8'h00;
  localparam logic [15:0] UVS_RST_RESULT = 16'h0000;
  // generation register: arbitrary neutral identity values
  localparam logic [3:0] UVS_PART_ID = 4'h5;
  localparam logic [3:0] UVS_LAYOUT_REV = 4'h3;
  // conversion timing: 1024 clocks per conversion, gap of 16 clocks
  localparam int UVS_CONV_CYCLES = 1024;
  localparam int UVS_GAP_CYCLES = 16;
  localparam logic [10:0] UVS_CONV_LAST = 11'(UVS_CONV_CYCLES - 1);
  localparam logic [10:0] UVS_GAP_LAST = 11'(UVS_GAP_CYCLES - 1);
  typedef enum logic [1:0] {
    UVS_ST_IDLE = 2'b00,
    UVS_ST_CONV = 2'b01,
    UVS_ST_GAP = 2'b11
  } uvs_meas_e;
endpackage

// ===== rtl/uvs_state_regs.sv
// uvs_state_regs: operational state register, generation register,
// access gating of control and result banks, measurement sequencer.
// assumes a byte-wide register port, strobes synchronous to clk.
`timescale 1ns/1ns

// Overview of operation
// - bit7 starts measurement in measurement state
// - bit6 power down, resets to one
// - soft reset bit always reads zero
// - bits2:0 select state, reset 010
// - config state: control bank open, no measuring
// - measure state: results open, controls blocked
// - back to config clears results, halts
// - no-change codes keep state, other bits apply
// - soft reset halts, config, restores registers
// - power down applies in both states
// - power down only between conversions
// - 83h enters and starts, 80h needs state
// - start with power down wakes internally
// - generation register: id and revision nibbles
// - ready falls at start, rises at end
// - powers up configuring with power down
module uvs_state_regs
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic clk_en,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // conversion data from the analog front end
  input wire logic [15:0] conv_data,
  // status toward pins and analog
  output logic ready,
  output logic analog_on,
  output logic meas_state,
  output logic ctrl_wr,
  output logic [7:0] ctrl_wdata
);
  import uvs_pkg::*;

  logic start_bit;
  logic pd_bit;
  logic [2:0] op_state_select;
  logic [7:0] ctrl_bank [UVS_ADDR_CTRL_LO:UVS_ADDR_CTRL_HI];
  logic [15:0] result [UVS_ADDR_RES_LO:UVS_ADDR_RES_HI];
  uvs_meas_e meas;
  logic [10:0] cnt;
  logic [1:0] chan;
  logic in_meas;
  logic wr_osc;
  logic srst;
  logic to_config;
  logic start_req;
  logic next_ctrl_ok;
  logic [7:0] next_rdata;
  logic halt;
  logic next_meas_state;
  logic next_pd_bit;

  assign in_meas = (op_state_select == UVS_SEL_MEAS);
  assign wr_osc = reg_wr && (reg_addr == UVS_ADDR_OSC);
  assign srst = wr_osc && reg_wdata[UVS_BIT_SRST];
  // state after this cycle; the status flag follows it without a cycle of lag
  assign next_meas_state = srst ? 1'b0
                           : (wr_osc && reg_wdata[UVS_SEL_HI:1] == 2'b01) ? reg_wdata[0]
                           : in_meas;
  // power bit as it will stand, so analog power follows a write at once
  assign next_pd_bit = srst ? UVS_RST_PD : wr_osc ? reg_wdata[UVS_BIT_PD] : pd_bit;
  // only a real transition from measurement clears results
  assign to_config = wr_osc && (reg_wdata[UVS_SEL_HI:0] == UVS_SEL_CONFIG)
                     && in_meas;
  // start counts only if the write leaves measurement selected, entering it included;
  // a start bit written together with a return to config must not stick
  assign start_req = wr_osc && reg_wdata[UVS_BIT_START] && next_meas_state;
  // any state write that does not start stops a running measurement
  assign halt = srst || to_config || (wr_osc && !start_req);
  assign next_ctrl_ok = reg_wr && !in_meas && reg_addr >= UVS_ADDR_CTRL_LO
                        && reg_addr <= UVS_ADDR_CTRL_HI;

  // state register fields; soft reset restores reset values
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_bit <= UVS_RST_START;
      pd_bit <= UVS_RST_PD;
      op_state_select <= UVS_SEL_CONFIG;
    end
    else if (clk_en)
    begin
      if (srst)
      begin
        start_bit <= UVS_RST_START;
        pd_bit <= UVS_RST_PD;
        op_state_select <= UVS_SEL_CONFIG;
      end
      else if (wr_osc)
      begin
        start_bit <= start_req;
        pd_bit <= reg_wdata[UVS_BIT_PD];
        // codes 00x and 1xx leave the state alone
        if (reg_wdata[UVS_SEL_HI:1] == 2'b01)
          op_state_select <= reg_wdata[UVS_SEL_HI:0];
      end
      else if (meas == UVS_ST_GAP && cnt == UVS_GAP_LAST && chan == 2'd0)
        start_bit <= 1'b0; // single measurement completes
    end
  end

  // control bank, writable only in configuration state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = UVS_ADDR_CTRL_LO; i <= UVS_ADDR_CTRL_HI; i++)
        ctrl_bank[i] <= UVS_RST_CTRL;
      ctrl_wr <= 1'b0;
      ctrl_wdata <= UVS_RST_CTRL;
    end
    else if (clk_en)
    begin
      ctrl_wr <= next_ctrl_ok;
      ctrl_wdata <= reg_wdata;
      if (srst)
      begin
        for (int i = UVS_ADDR_CTRL_LO; i <= UVS_ADDR_CTRL_HI; i++)
          ctrl_bank[i] <= UVS_RST_CTRL;
      end
      else if (next_ctrl_ok)
        ctrl_bank[reg_addr] <= reg_wdata;
    end
  end

  // measurement sequencer: three channel conversions then a gap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meas <= UVS_ST_IDLE;
      cnt <= 11'h000;
      chan <= 2'd0;
    end
    else if (clk_en)
    begin
      if (halt)
      begin
        meas <= UVS_ST_IDLE; // halts at once
        cnt <= 11'h000;
        chan <= 2'd0;
      end
      else
      begin
        unique case (meas)
          UVS_ST_IDLE:
          begin
            if (start_req)
              meas <= UVS_ST_CONV; // only reachable in measurement
            cnt <= 11'h000;
          end
          UVS_ST_CONV:
          begin
            cnt <= cnt + 11'h001;
            if (cnt == UVS_CONV_LAST)
            begin
              cnt <= 11'h000;
              if (chan == 2'd2)
              begin
                chan <= 2'd0;
                meas <= UVS_ST_GAP;
              end
              else
                chan <= chan + 2'd1;
            end
          end
          UVS_ST_GAP:
          begin
            cnt <= cnt + 11'h001;
            if (cnt == UVS_GAP_LAST)
              meas <= UVS_ST_IDLE;
          end
          default:
            meas <= UVS_ST_IDLE;
        endcase
      end
    end
  end

  // result capture per channel; cleared on return to config
  generate
    for (genvar g = 0; g < 3; g++)
    begin : g_res
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
          result[UVS_ADDR_RES_LO + g] <= UVS_RST_RESULT;
        else if (clk_en)
        begin
          if (srst || to_config)
            result[UVS_ADDR_RES_LO + g] <= UVS_RST_RESULT;
          else if (meas == UVS_ST_CONV && cnt == UVS_CONV_LAST && chan == 2'(g))
            result[UVS_ADDR_RES_LO + g] <= conv_data;
        end
      end
    end
  endgenerate

  // ready and analog power; power down waits for the gap
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ready <= 1'b1;
      analog_on <= 1'b0;
      meas_state <= 1'b0;
    end
    else if (clk_en)
    begin
      meas_state <= next_meas_state;
      if (start_req && meas == UVS_ST_IDLE)
        ready <= 1'b0;
      else if (halt)
        ready <= 1'b1; // a stopped measurement reports idle at once
      else if (meas == UVS_ST_CONV && cnt == UVS_CONV_LAST && chan == 2'd2)
        ready <= 1'b1;
      else if (meas == UVS_ST_IDLE)
        ready <= 1'b1;
      // wake for a started measurement overrides power down
      if (start_req || meas == UVS_ST_CONV)
        analog_on <= 1'b1;
      else
        analog_on <= !next_pd_bit;
    end
  end

  // read mux, one byte per read, answered the next cycle
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_addr == UVS_ADDR_OSC)
      next_rdata = {start_bit, pd_bit, 2'b00, 1'b0, op_state_select};
    else if (!in_meas && reg_addr == UVS_ADDR_GEN)
      next_rdata = {UVS_PART_ID, UVS_LAYOUT_REV};
    else if (!in_meas && reg_addr >= UVS_ADDR_CTRL_LO && reg_addr <= UVS_ADDR_CTRL_HI)
      next_rdata = ctrl_bank[reg_addr];
    else if (in_meas && reg_addr >= UVS_ADDR_RES_LO && reg_addr <= UVS_ADDR_RES_HI)
      next_rdata = result[reg_addr][7:0]; // low byte
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rvalid <= reg_rd;
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // checks
  sequence s_start_wr;
    clk_en && start_req && meas == UVS_ST_IDLE;
  endsequence

  sequence s_halt_wr;
    clk_en && halt;
  endsequence

  sequence s_last_conv;
    clk_en && meas == UVS_ST_CONV && cnt == UVS_CONV_LAST && chan == 2'd2;
  endsequence

  a_ready_falls: assert property (@(posedge clk) disable iff (rst)
    s_start_wr |=> !ready) else $error("ready did not fall on start");
  a_ready_rises: assert property (@(posedge clk) disable iff (rst)
    s_last_conv |=> ready) else $error("ready did not rise at conversion end");
  a_halt_ready: assert property (@(posedge clk) disable iff (rst)
    s_halt_wr |=> ready && meas == UVS_ST_IDLE) else $error("halt left a conversion running");
  a_srst_config: assert property (@(posedge clk) disable iff (rst)
    clk_en && srst |=> op_state_select == UVS_SEL_CONFIG && pd_bit && meas == UVS_ST_IDLE)
    else $error("soft reset did not restore state");
  a_nop_keeps: assert property (@(posedge clk) disable iff (rst)
    clk_en && wr_osc && !srst && reg_wdata[2:1] != 2'b01 |=> $stable(op_state_select))
    else $error("no-change code altered state");
  a_meas_flag: assert property (@(posedge clk) disable iff (rst)
    clk_en |=> meas_state == in_meas) else $error("state flag out of step with state");
  a_config_clears: assert property (@(posedge clk) disable iff (rst)
    clk_en && to_config && !srst |=> result[UVS_ADDR_RES_LO] == 16'h0000
    && meas == UVS_ST_IDLE) else $error("results not cleared");
  a_no_conv_cfg: assert property (@(posedge clk) disable iff (rst)
    !in_meas |-> meas != UVS_ST_CONV) else $error("conversion in configuration");
  a_srst_reads0: assert property (@(posedge clk) disable iff (rst)
    reg_rvalid |-> !reg_rdata[UVS_BIT_SRST] || $past(reg_addr) != UVS_ADDR_OSC)
    else $error("soft reset bit read as one");
  a_ctrl_blocked: assert property (@(posedge clk) disable iff (rst)
    clk_en && reg_wr && in_meas |=> !ctrl_wr) else $error("control write in measurement");
  a_wake_conv: assert property (@(posedge clk) disable iff (rst)
    clk_en && meas == UVS_ST_CONV |=> analog_on) else $error("powered down in conversion");
  a_pd_idle: assert property (@(posedge clk) disable iff (rst)
    clk_en && !start_req && meas != UVS_ST_CONV && next_pd_bit |=> !analog_on)
    else $error("power down ignored outside conversion");
endmodule

// ===== tb/uv_sensor_state_control_regs_tb.sv
// uv_sensor_state_control_regs_tb: directed scenarios for the state register bank.
// assumes the host model drives the register port; clk_en held high except for the frozen write in t_freeze_rst.
`timescale 1ns/1ns
module uv_sensor_state_control_regs_tb;
  import uvs_pkg::*;
  logic clk, rst, clk_en, reg_wr, reg_rd, reg_rvalid, ready, analog_on, meas_state, ctrl_wr;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, ctrl_wdata;
  logic [15:0] conv_data;
  int cmp_count, mismatches;
  uvs_state_regs DUT (.clk(clk), .rst(rst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .conv_data(conv_data), .ready(ready), .analog_on(analog_on),
    .meas_state(meas_state), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
  uvs_host_model HOST (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // 250 MHz
  always #2 clk = ~clk;
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask
  // read one register; the valid pulse is part of the match
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    HOST.rd(a, d, v);
    chk({7'h00, v, d}, {8'h01, e});
  endtask
  // bounded wait for the end of a three channel conversion
  task automatic wait_ready;
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 4000)
    begin
      mismatches++;
      $display("ERROR t=%0t ready never rose", $time);
      wrap_up();
    end
  endtask
  task automatic t_reset;
    chk({ready, analog_on, meas_state}, 3'b100);
    rchk(UVS_ADDR_OSC, 8'h42);
    rchk(UVS_ADDR_GEN, {UVS_PART_ID, UVS_LAYOUT_REV});
  endtask
  task automatic t_config;
    HOST.wr(UVS_ADDR_CTRL_LO, 8'hA6);
    chk({ctrl_wr, ctrl_wdata}, 9'h1A6);
    HOST.wr(UVS_ADDR_OSC, 8'h80);
    chk({ready, meas_state, analog_on}, 3'b101);
  endtask
  // no-change codes keep the state while the power bit still lands
  task automatic t_codes;
    logic [2:0] c [6] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 6; i++)
    begin
      HOST.wr(UVS_ADDR_OSC, {1'b0, i[0], 2'b11, 1'b0, c[i]});
      chk({meas_state, analog_on}, {1'b0, !i[0]});
      rchk(UVS_ADDR_OSC, {1'b0, i[0], 6'h02});
    end
  endtask
  task automatic t_measure;
    HOST.wr(UVS_ADDR_OSC, 8'h03);
    chk({meas_state, ready}, 2'b11);
    HOST.wr(UVS_ADDR_OSC, 8'h80);
    chk({ready, analog_on}, 2'b01);
    HOST.wr(UVS_ADDR_CTRL_HI, 8'h55);
    chk(ctrl_wr, 1'b0);
    rchk(UVS_ADDR_GEN, 8'h00);
    wait_ready();
    rchk(UVS_ADDR_RES_LO, conv_data[7:0]);
  endtask
  // back to configuration clears results
  task automatic t_back;
    HOST.wr(UVS_ADDR_OSC, 8'h02);
    chk(meas_state, 1'b0);
    rchk(UVS_ADDR_CTRL_LO, 8'hA6);
    HOST.wr(UVS_ADDR_OSC, 8'h03);
    rchk(UVS_ADDR_RES_LO, 8'h00);
  endtask
  // start under power down, then soft reset mid-conversion
  task automatic t_wake_srst;
    HOST.wr(UVS_ADDR_OSC, 8'hC3);
    chk({meas_state, ready, analog_on}, 3'b101);
    HOST.wr(UVS_ADDR_OSC, 8'hC0);
    chk({meas_state, ready, analog_on}, 3'b101);
    rchk(UVS_ADDR_OSC, 8'hC3);
    HOST.wr(UVS_ADDR_OSC, 8'h0A);
    chk({meas_state, ready}, 2'b01);
    rchk(UVS_ADDR_OSC, 8'h42);
    chk(analog_on, 1'b0);
  endtask
  // frozen clock enable ignores a write; reset mid-conversion restores defaults
  task automatic t_freeze_rst;
    @(posedge clk);
    clk_en <= 1'b0;
    HOST.wr(UVS_ADDR_OSC, 8'h83);
    chk({meas_state, ready, analog_on}, 3'b010);
    @(posedge clk);
    clk_en <= 1'b1;
    HOST.wr(UVS_ADDR_CTRL_LO, 8'h5A);
    HOST.wr(UVS_ADDR_OSC, 8'h83);
    chk({meas_state, ready, analog_on}, 3'b101);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({meas_state, ready, analog_on}, 3'b010);
    rchk(UVS_ADDR_OSC, 8'h42);
    rchk(UVS_ADDR_CTRL_LO, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    conv_data = 16'h1234;
    cmp_count = 0;
    mismatches = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_config();
    t_codes();
    t_measure();
    t_back();
    t_wake_srst();
    t_freeze_rst();
    wrap_up();
  end
endmodule

// ===== tb/uvs_host_model.sv
// uvs_host_model: register host issuing single byte writes and reads.
// assumes the bench calls its tasks; every drive change follows a rising edge.
`timescale 1ns/1ns
module uvs_host_model
(
  // clock
  input wire logic clk,
  // register port toward the device
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // idle bus from time zero
  initial
  begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // write held to the taking edge; released lines show the inverse, not stale data
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    #1;
  endtask
  // read; answer is registered, so it is taken just after the taking edge
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule
